// >>> include/tmb_pkg.sv
// Purpose: constants and types shared by the tag memory bank access block
// Assumes: 64 pages of four 16-bit words; word addresses are physical
// Notes: access checker and main block both import this package
//
// Summary of operation
// - After reset, load configuration, then pick protocol
// - Reader-first mode allows memory read and write
// - 64 pages of 4 words; block equals page
// - Last five User pages hold system configuration
// - Banks contiguous; TID bank never writable
// - Bank sizes 1, 4, 6, 53 pages
// - BlockWrite 1-4 in-page words; UII page 0 refused
// - BlockErase 1-4 words within one page
// - BlockErase refused on UII page 0, clock words
// - BlockPermalock whole pages, User bank only
// - Backscatter is ASK only, no PSK
// - Flex_Query supports M of 2 to 64
// - BroadcastSync accepted only in battery-assisted mode
// - Listen-first mode supports pulse-position and Miller
// - TID bank holds extended TID content
// - Codes: no-protection open, no-access refused, standard locked
package tmb_pkg;
  // ==========================================================
  // geometry
  localparam int WORD_W = 16;
  localparam int NVM_WORDS = 256;
  localparam logic [5:0] BASE_RSV = 6'h00;
  localparam logic [5:0] BASE_TID = 6'h01;
  localparam logic [5:0] BASE_UII = 6'h05;
  localparam logic [5:0] BASE_USR = 6'h0b;
  localparam logic [5:0] PG_RSV = 6'h01;
  localparam logic [5:0] PG_TID = 6'h04;
  localparam logic [5:0] PG_UII = 6'h06;
  localparam logic [5:0] PG_USR = 6'h35;
  localparam logic [5:0] SYS_FIRST_PAGE = 6'h3b;
  localparam logic [2:0] BLK_WORDS = 3'h4;
  // ==========================================================
  // configuration words read at boot
  localparam logic [7:0] ADR_PCW = 8'h15;
  localparam logic [7:0] ADR_BATT = 8'hf1;
  localparam logic [7:0] ADR_TOTAL = 8'hf3;
  localparam logic [7:0] ADR_PLOCK = 8'hf8;
  localparam logic [7:0] ADR_BLOCK = 8'hfc;
  localparam logic [2:0] BOOT_LAST = 3'h7;
  localparam int TOTAL_EN_BIT = 0;
  localparam int BAP_EN_BIT = 0;
  localparam logic [15:0] ERASE_VAL = 16'h0000;
  // ==========================================================
  // supported optional features
  localparam logic ASK_ONLY = 1'b1;
  localparam logic PSK_OFFERED = 1'b0;
  localparam logic [5:0] FLEX_M_MASK = 6'h3f;
  localparam logic ENC_PPE = 1'b1;
  localparam logic ENC_MILLER = 1'b1;
  localparam logic XTID_PRESENT = 1'b1;
  // ==========================================================
  // commands, banks, answers
  typedef enum logic [2:0] {
    OP_READ = 3'h0, OP_WRITE = 3'h1, OP_BWRITE = 3'h2,
    OP_BERASE = 3'h3, OP_PLOCK = 3'h4
  } tmb_op_t;
  typedef enum logic [1:0] {
    BK_RSV = 2'h0, BK_TID = 2'h1, BK_UII = 2'h2, BK_USR = 2'h3
  } tmb_bank_t;
  localparam logic [3:0] ERR_OTHER = 4'h0;
  localparam logic [3:0] ERR_OVERRUN = 4'h3;
  localparam logic [3:0] ERR_LOCKED = 4'h4;
  localparam logic [3:0] ERR_NONE = 4'hf;
endpackage : tmb_pkg

// >>> include/tmb_chk_if.sv
// Purpose: request and verdict between the main block and access checker
// Assumes: purely combinational path, same clock
// Notes: none
`timescale 1ns/10ps
interface tmb_chk_if;
  import tmb_pkg::*;
  tmb_op_t op;
  tmb_bank_t bank;
  logic [7:0] wptr;
  logic [2:0] wcnt;
  logic [63:0] perma;
  logic [3:0] bank_lock;
  logic ok;
  logic [3:0] err;
  logic [8:0] phys;
  modport req (output op, bank, wptr, wcnt, perma, bank_lock, input ok, err, phys);
  modport chk (input op, bank, wptr, wcnt, perma, bank_lock, output ok, err, phys);
endinterface : tmb_chk_if

// >>> hw/tmb_access_check.sv
// Purpose: decide whether one memory command may proceed
// Assumes: wptr is a word pointer inside the named bank
// Notes: first failing test sets the error code
`timescale 1ns/10ps
module tmb_access_check import tmb_pkg::*; (
  tmb_chk_if.chk ck
);
  logic [5:0] base;
  logic [5:0] size;
  logic [5:0] lpage;
  logic [2:0] last;
  logic blk;
  logic wr;

  always_comb begin
    unique case (ck.bank)
      BK_RSV: begin base = BASE_RSV; size = PG_RSV; end
      BK_TID: begin base = BASE_TID; size = PG_TID; end
      BK_UII: begin base = BASE_UII; size = PG_UII; end
      BK_USR: begin base = BASE_USR; size = PG_USR; end
    endcase
    lpage = ck.wptr[7:2];
    last = {1'b0, ck.wptr[1:0]} + ck.wcnt - 3'h1;
    ck.phys = {1'b0, base, 2'b00} + {1'b0, ck.wptr};
    blk = (ck.op == OP_BWRITE) || (ck.op == OP_BERASE);
    wr = ck.op != OP_READ;
    ck.ok = 1'b0;
    // ==========================================================
    // ordered checks
    // clock words sit past the stored User pages, so overrun refuses them
    if (lpage >= size) begin
      ck.err = ERR_OVERRUN;
    end else if (blk && (ck.wcnt == 3'h0 || ck.wcnt > BLK_WORDS || last >= BLK_WORDS)) begin
      ck.err = ERR_OVERRUN;
    end else if (blk && ck.bank == BK_UII && lpage == 6'h00) begin
      ck.err = ERR_OTHER;
    end else if (ck.op == OP_PLOCK && (ck.bank != BK_USR || ck.wptr[1:0] != 2'h0)) begin
      ck.err = ERR_OTHER;
    end else if (wr && ck.bank == BK_TID) begin
      ck.err = ERR_LOCKED;
    end else if (wr && ck.bank == BK_UII && ck.wptr == 8'h00) begin
      ck.err = ERR_OTHER;
    end else if ((wr || ck.bank == BK_RSV) && ck.bank_lock[ck.bank]) begin
      ck.err = ERR_LOCKED;
    end else if (wr && ck.op != OP_PLOCK && ck.perma[ck.phys[7:2]]) begin
      ck.err = ERR_LOCKED;
    end else begin
      ck.ok = 1'b1;
      ck.err = ERR_NONE;
    end
  end
endmodule : tmb_access_check

// >>> hw/tmb_bank_access.sv
// Purpose: non-volatile word store split into four banks, boot loader, command engine
// Assumes: commands come from protocol logic on mclk; store keeps contents over srst
// Notes: one word is written per cycle; answers are one-cycle pulses
`timescale 1ns/10ps
module tmb_bank_access import tmb_pkg::*; (
  input wire logic mclk,
  input wire logic srst,
  input wire logic reader_first_seen,
  input wire logic reader_first_over,
  input wire logic bsync_req,
  input wire logic cmd_valid,
  input wire tmb_op_t cmd_op,
  input wire tmb_bank_t cmd_bank,
  input wire logic [7:0] cmd_wptr,
  input wire logic [2:0] cmd_wcnt,
  input wire logic [63:0] cmd_wdata,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic rsp_ok,
  output logic [3:0] rsp_err,
  output logic [15:0] rsp_rdata,
  output logic boot_done,
  output logic reader_first_protocol,
  output logic listen_first_active,
  output logic [15:0] protocol_control_word,
  output logic bap_active,
  output logic bsync_ack,
  output logic ask_only,
  output logic psk_offered,
  output logic [5:0] flex_m_mask,
  output logic enc_ppe,
  output logic enc_miller,
  output logic xtid_present
);
  // ==========================================================
  // state
  typedef enum logic [1:0] {
    S_BOOT = 2'b00, S_IDLE = 2'b01, S_EXEC = 2'b10
  } tmb_st_t;

  typedef struct packed {
    tmb_st_t st;
    logic [2:0] bidx;
    tmb_op_t op;
    logic [7:0] addr;
    logic [1:0] widx;
    logic [1:0] wlast;
    logic [63:0] wdata;
    logic [15:0] pcw;
    logic total_en;
    logic bap;
    logic [63:0] perma;
    logic [3:0] bank_lock;
    logic rf;
    logic lf;
    logic boot_done;
    logic cmd_ready;
    logic rsp_valid;
    logic rsp_ok;
    logic [3:0] rsp_err;
    logic [15:0] rsp_rdata;
    logic bsync_ack;
    logic ask_only;
    logic psk_offered;
    logic [5:0] flex_m_mask;
    logic enc_ppe;
    logic enc_miller;
    logic xtid;
  } tmb_state_t;

  localparam tmb_state_t ST_RESET = '{
    st: S_BOOT,
    bidx: 3'h0,
    op: OP_READ,
    addr: 8'h00,
    widx: 2'h0,
    wlast: 2'h0,
    wdata: 64'h0,
    pcw: 16'h0000,
    total_en: 1'b0,
    bap: 1'b0,
    perma: 64'h0,
    bank_lock: 4'h0,
    rf: 1'b0,
    lf: 1'b0,
    boot_done: 1'b0,
    cmd_ready: 1'b0,
    rsp_valid: 1'b0,
    rsp_ok: 1'b0,
    rsp_err: ERR_NONE,
    rsp_rdata: 16'h0000,
    bsync_ack: 1'b0,
    ask_only: 1'b0,
    psk_offered: 1'b0,
    flex_m_mask: 6'h00,
    enc_ppe: 1'b0,
    enc_miller: 1'b0,
    xtid: 1'b0
  };

  tmb_state_t st_reg;
  tmb_state_t st_next;

  // no reset on the store: it models non-volatile cells
  logic [15:0] mem [0:NVM_WORDS-1];
  logic mem_we;
  logic [7:0] mem_wa;
  logic [15:0] mem_wd;
  logic [7:0] boot_a;
  logic [15:0] boot_w;
  logic [15:0] cmd_w;
  logic [15:0] exec_w;
  logic [7:0] lock_a;
  logic [15:0] lock_w;
  logic take;

  tmb_chk_if chk ();

  tmb_access_check u_check (
    .ck(chk.chk)
  );

  // ==========================================================
  // helpers
  // the PCW boot word sits in UII page 0; the other boot words sit in the system pages at the top of User
  function automatic logic [7:0] boot_addr(input logic [2:0] idx);
    logic [7:0] a;
    a = ADR_BLOCK;
    unique case (idx)
      3'h0: a = ADR_PCW;
      3'h1: a = ADR_TOTAL;
      3'h2: a = ADR_BATT;
      3'h3: a = ADR_PLOCK;
      3'h4: a = ADR_PLOCK + 8'h01;
      3'h5: a = ADR_PLOCK + 8'h02;
      3'h6: a = ADR_PLOCK + 8'h03;
      3'h7: a = ADR_BLOCK;
    endcase
    return a;
  endfunction : boot_addr

  assign chk.op = cmd_op;
  assign chk.bank = cmd_bank;
  assign chk.wptr = cmd_wptr;
  assign chk.wcnt = cmd_wcnt;
  assign chk.perma = st_reg.perma;
  assign chk.bank_lock = st_reg.bank_lock;

  assign boot_a = boot_addr(st_reg.bidx);
  assign boot_w = mem[boot_a];
  assign cmd_w = mem[chk.phys[7:0]];
  // permalock bits: one bit per physical page, four words cover 64 pages
  assign lock_a = ADR_PLOCK + {6'h00, chk.phys[7:6]};
  assign lock_w = mem[lock_a] | (16'h0001 << chk.phys[5:2]);
  // a command is taken on the edge that sees both valid and ready
  assign take = st_reg.cmd_ready && cmd_valid;

  always_comb begin
    unique case (st_reg.widx)
      2'h0: exec_w = st_reg.wdata[15:0];
      2'h1: exec_w = st_reg.wdata[31:16];
      2'h2: exec_w = st_reg.wdata[47:32];
      2'h3: exec_w = st_reg.wdata[63:48];
    endcase
  end

  // ==========================================================
  // next state
  always_comb begin
    st_next = st_reg;
    st_next.rsp_valid = 1'b0;
    st_next.bsync_ack = 1'b0;
    mem_we = 1'b0;
    mem_wa = st_reg.addr;
    mem_wd = exec_w;
    st_next.bsync_ack = bsync_req && st_reg.bap && st_reg.boot_done;
    unique case (st_reg.st)
      S_BOOT: begin
        // one boot word per cycle, eight cycles in all
        unique case (st_reg.bidx)
          3'h0: st_next.pcw = boot_w;
          3'h1: st_next.total_en = boot_w[TOTAL_EN_BIT];
          3'h2: st_next.bap = boot_w[BAP_EN_BIT];
          3'h3: st_next.perma[15:0] = boot_w;
          3'h4: st_next.perma[31:16] = boot_w;
          3'h5: st_next.perma[47:32] = boot_w;
          3'h6: st_next.perma[63:48] = boot_w;
          3'h7: st_next.bank_lock = boot_w[3:0];
        endcase
        st_next.bidx = st_reg.bidx + 3'h1;
        if (st_reg.bidx == BOOT_LAST) begin
          st_next.st = S_IDLE;
          st_next.boot_done = 1'b1;
          st_next.lf = st_reg.total_en;
          st_next.rf = !st_reg.total_en;
          st_next.cmd_ready = !st_reg.total_en;
          st_next.ask_only = ASK_ONLY;
          st_next.psk_offered = PSK_OFFERED;
          st_next.flex_m_mask = FLEX_M_MASK;
          st_next.enc_ppe = ENC_PPE;
          st_next.enc_miller = ENC_MILLER;
          st_next.xtid = XTID_PRESENT;
        end
      end
      S_IDLE: begin
        // switch between listen-first and reader-first between commands only
        if (st_reg.lf && reader_first_seen) begin
          st_next.lf = 1'b0;
          st_next.rf = 1'b1;
          st_next.cmd_ready = 1'b1;
        end else if (st_reg.rf && reader_first_over && st_reg.total_en && !take) begin
          st_next.lf = 1'b1;
          st_next.rf = 1'b0;
          st_next.cmd_ready = 1'b0;
        end
        // single-cycle ops and refusals answer next cycle; accepted block ops move to S_EXEC
        if (take) begin
          st_next.rsp_ok = chk.ok;
          st_next.rsp_err = chk.err;
          st_next.rsp_rdata = 16'h0000;
          st_next.op = cmd_op;
          st_next.addr = chk.phys[7:0];
          st_next.widx = 2'h0;
          st_next.wlast = cmd_wcnt[1:0] - 2'h1;
          st_next.wdata = cmd_wdata;
          if (!chk.ok || cmd_op == OP_READ) begin
            st_next.rsp_valid = 1'b1;
            if (chk.ok) begin
              st_next.rsp_rdata = cmd_w;
            end
          end else if (cmd_op == OP_WRITE) begin
            mem_we = 1'b1;
            mem_wa = chk.phys[7:0];
            mem_wd = cmd_wdata[15:0];
            st_next.rsp_valid = 1'b1;
          end else if (cmd_op == OP_PLOCK) begin
            mem_we = 1'b1;
            mem_wa = lock_a;
            mem_wd = lock_w;
            st_next.perma[chk.phys[7:2]] = 1'b1;
            st_next.rsp_valid = 1'b1;
          end else begin
            st_next.st = S_EXEC;
            st_next.cmd_ready = 1'b0;
          end
        end
      end
      S_EXEC: begin
        // one word per cycle; the page check already bounds the walk
        mem_we = 1'b1;
        mem_wd = st_reg.op == OP_BERASE ? ERASE_VAL : exec_w;
        st_next.addr = st_reg.addr + 8'h01;
        st_next.widx = st_reg.widx + 2'h1;
        if (st_reg.widx == st_reg.wlast) begin
          st_next.st = S_IDLE;
          st_next.rsp_valid = 1'b1;
          st_next.cmd_ready = st_reg.rf;
        end
      end
      default: begin
        st_next.st = S_IDLE;
      end
    endcase
  end

  // ==========================================================
  // registers and store
  always_ff @(posedge mclk) begin
    if (srst) begin
      st_reg <= ST_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================
  // store write port
  // plain always so the cells can also be preloaded from outside
  // writes are held off during srst so a reset never alters a cell
  always @(posedge mclk) begin
    if (mem_we && !srst) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  // ==========================================================
  // outputs, each a field of the state register
  assign cmd_ready = st_reg.cmd_ready;
  assign rsp_valid = st_reg.rsp_valid;
  assign rsp_ok = st_reg.rsp_ok;
  assign rsp_err = st_reg.rsp_err;
  assign rsp_rdata = st_reg.rsp_rdata;
  assign boot_done = st_reg.boot_done;
  assign reader_first_protocol = st_reg.rf;
  assign listen_first_active = st_reg.lf;
  assign protocol_control_word = st_reg.pcw;
  assign bap_active = st_reg.bap;
  assign bsync_ack = st_reg.bsync_ack;
  assign ask_only = st_reg.ask_only;
  assign psk_offered = st_reg.psk_offered;
  assign flex_m_mask = st_reg.flex_m_mask;
  assign enc_ppe = st_reg.enc_ppe;
  assign enc_miller = st_reg.enc_miller;
  assign xtid_present = st_reg.xtid;
endmodule : tmb_bank_access

// >>> tb/tmb_bank_access_properties.sv
// Purpose: port-level checks of the bank access block
// Assumes: one mclk domain, srst sync high
// Notes: bound to every tmb_bank_access
`timescale 1ns/10ps
module tmb_bank_access_properties import tmb_pkg::*; (
  input wire logic mclk,
  input wire logic srst,
  input wire logic bsync_req,
  input wire logic cmd_valid,
  input wire tmb_op_t cmd_op,
  input wire tmb_bank_t cmd_bank,
  input wire logic [7:0] cmd_wptr,
  input wire logic [2:0] cmd_wcnt,
  input wire logic cmd_ready,
  input wire logic rsp_valid,
  input wire logic rsp_ok,
  input wire logic [3:0] rsp_err,
  input wire logic boot_done,
  input wire logic reader_first_protocol,
  input wire logic listen_first_active,
  input wire logic bap_active,
  input wire logic bsync_ack,
  input wire logic ask_only,
  input wire logic psk_offered,
  input wire logic [5:0] flex_m_mask,
  input wire logic enc_ppe,
  input wire logic enc_miller,
  input wire logic xtid_present
);
  // ==========================================================
  // command decode
  logic take;
  logic blk;
  logic [3:0] span;
  assign take = cmd_valid && cmd_ready;
  assign blk = cmd_op == OP_BWRITE || cmd_op == OP_BERASE;
  // four bits so a count of 7 at offset 3 cannot wrap back into the page
  assign span = {2'h0, cmd_wptr[1:0]} + {1'b0, cmd_wcnt};
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);
  chk_single_answer: assert property (take && !blk |=> rsp_valid)
    else $error("command not answered");
  chk_ok_code: assert property (rsp_valid |-> rsp_ok == (rsp_err == ERR_NONE))
    else $error("flag and code disagree");
  chk_page_cross: assert property (
    take && blk && (span > 4'h4 || cmd_wcnt == 3'h0) |=> rsp_valid && rsp_err == ERR_OVERRUN)
    else $error("block span not refused");
  chk_uii_page0: assert property (
    take && blk && cmd_bank == BK_UII && cmd_wptr[7:2] == 6'h00 && cmd_wcnt != 3'h0 && span <= 4'h4
    |=> rsp_valid && rsp_err == ERR_OTHER)
    else $error("block on first id page not refused");
  chk_plock_bank: assert property (take && cmd_op == OP_PLOCK && cmd_bank != BK_USR |=> !rsp_ok)
    else $error("permalock outside user bank");
  chk_tid_locked: assert property (take && cmd_op != OP_READ && cmd_bank == BK_TID |=> !rsp_ok)
    else $error("tid bank altered");
  chk_feature_set: assert property (boot_done |-> ask_only && !psk_offered && flex_m_mask == 6'h3f
    && enc_ppe && enc_miller && xtid_present)
    else $error("feature flags wrong");
  chk_bsync_gate: assert property (bsync_req && bap_active && boot_done |-> ##[1:2] bsync_ack)
    else $error("sync not acknowledged");
  chk_bsync_refuse: assert property (!(bsync_req && bap_active && boot_done) |=> !bsync_ack)
    else $error("sync acknowledged while refused");
  chk_boot_window: assert property ($fell(srst) |-> !boot_done ##[1:10] boot_done)
    else $error("boot not finished in time");
  chk_one_protocol: assert property (boot_done |-> reader_first_protocol != listen_first_active)
    else $error("protocol state ambiguous");
endmodule : tmb_bank_access_properties

bind tmb_bank_access tmb_bank_access_properties u_props (.*);

// >>> tb/tmb_reader_model.sv
// Purpose: reader side issuing memory commands
// Assumes: send is entered just after a rising mclk edge
// Notes: released pointer and data lines are inverted; op, bank and count are held
`timescale 1ns/10ps
module tmb_reader_model import tmb_pkg::*; (
  input wire logic mclk,
  input wire logic cmd_ready,
  input wire logic rsp_valid,
  input wire logic rsp_ok,
  input wire logic [3:0] rsp_err,
  input wire logic [15:0] rsp_rdata,
  output logic cmd_valid,
  output tmb_op_t cmd_op,
  output tmb_bank_t cmd_bank,
  output logic [7:0] cmd_wptr,
  output logic [2:0] cmd_wcnt,
  output logic [63:0] cmd_wdata
);
  initial begin
    cmd_valid = 1'b0;
    cmd_op = OP_READ;
    cmd_bank = BK_RSV;
    cmd_wptr = 8'h00;
    cmd_wcnt = 3'h0;
    cmd_wdata = 64'h0;
  end
  // ==========================================================
  // one command, held until taken, then its answer
  task automatic send(input tmb_op_t op, input tmb_bank_t bk, input logic [7:0] wp, input logic [2:0] wc,
      input logic [63:0] wd, output logic ok, output logic [3:0] er, output logic [15:0] rd);
    int n;
    n = 0;
    cmd_op = op;
    cmd_bank = bk;
    cmd_wptr = wp;
    cmd_wcnt = wc;
    cmd_wdata = wd;
    cmd_valid = 1'b1;
    while (!cmd_ready && n < 30) begin
      @(posedge mclk);
      #1;
      n++;
    end
    @(posedge mclk);
    #1;
    cmd_valid = 1'b0;
    cmd_wptr = ~wp;
    cmd_wdata = ~wd;
    while (!rsp_valid && n < 30) begin
      @(posedge mclk);
      #1;
      n++;
    end
    // a lost answer must never look like a good one
    ok = n < 30 ? rsp_ok : 1'bx;
    er = rsp_err;
    rd = rsp_rdata;
  endtask : send
endmodule : tmb_reader_model

// >>> tb/tmb_bank_access_tb.sv
// Purpose: self-checking bench for tmb_bank_access
// Assumes: store preloaded through hierarchy before boot
// Notes: each word holds 5a and its physical address unless set for boot
`timescale 1ns/10ps
module tmb_bank_access_tb import tmb_pkg::*;;
  localparam logic [15:0] PCW_VAL = 16'h3c5a;
  logic mclk, srst, reader_first_seen, reader_first_over, bsync_req, cmd_valid, cmd_ready, rsp_valid, rsp_ok;
  logic reader_first_protocol, listen_first_active, bap_active, bsync_ack, ask_only, psk_offered;
  logic enc_ppe, enc_miller, xtid_present, boot_done;
  tmb_op_t cmd_op;
  tmb_bank_t cmd_bank;
  logic [7:0] cmd_wptr;
  logic [2:0] cmd_wcnt;
  logic [63:0] cmd_wdata;
  logic [3:0] rsp_err;
  logic [15:0] rsp_rdata, protocol_control_word;
  logic [5:0] flex_m_mask;
  int fails = 0;
  int comparisons = 0;
  int cycles = 0;
  tmb_bank_access DUT (.*);
  tmb_reader_model RDR (.*);
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fails = fails + 1;
      give_verdict();
    end
  end
  // ==========================================================
  // compares and the command helper
  task automatic cmp_bit(input string nm, input logic e, input logic g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %b seen %b", nm, e, g);
    end
  endtask : cmp_bit
  task automatic cmp_word(input string nm, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp_word
  task automatic cmd(input tmb_op_t op, input tmb_bank_t bk, input logic [7:0] wp, input logic [2:0] wc,
      input logic [63:0] wd, input logic eok, input logic [3:0] eer, input logic [15:0] erd);
    logic ok;
    logic [3:0] er;
    logic [15:0] rd;
    RDR.send(op, bk, wp, wc, wd, ok, er, rd);
    cmp_bit("rsp_ok", eok, ok);
    cmp_word("rsp_err", {12'h000, eer}, {12'h000, er});
    cmp_word("rsp_rdata", erd, rd);
  endtask : cmd
  task automatic step();
    @(posedge mclk);
    #1;
  endtask : step
  // ==========================================================
  // scenarios
  task automatic t_boot();
    cmp_bit("listen_first_active", 1'b1, listen_first_active);
    cmp_bit("cmd_ready", 1'b0, cmd_ready);
    cmp_word("protocol_control_word", PCW_VAL, protocol_control_word);
    cmp_bit("bap_active", 1'b1, bap_active);
    cmp_word("features", 16'h05ff, {5'h00, ask_only, psk_offered, flex_m_mask, enc_ppe, enc_miller, xtid_present});
    reader_first_seen = 1'b1;
    step();
    reader_first_seen = 1'b0;
    step();
    cmp_bit("reader_first_protocol", 1'b1, reader_first_protocol);
    cmp_bit("cmd_ready", 1'b1, cmd_ready);
    $display("boot test done");
  endtask : t_boot
  task automatic t_bounds();
    tmb_bank_t bk [4] = '{BK_RSV, BK_TID, BK_UII, BK_USR};
    logic [7:0] last [4] = '{8'h03, 8'h0f, 8'h17, 8'hd3};
    logic [7:0] base [4] = '{8'h00, 8'h04, 8'h14, 8'h2c};
    cmd(OP_READ, BK_UII, 8'h01, 3'h0, 64'h0, 1'b1, ERR_NONE, PCW_VAL);
    for (int b = 0; b < 4; b++) begin
      cmd(OP_READ, bk[b], last[b], 3'h0, 64'h0, 1'b1, ERR_NONE, {8'h5a, base[b] + last[b]});
      cmd(OP_READ, bk[b], last[b] + 8'h01, 3'h0, 64'h0, 1'b0, ERR_OVERRUN, 16'h0000);
    end
    $display("bounds test done");
  endtask : t_bounds
  task automatic t_block();
    logic [15:0] e;
    cmd(OP_WRITE, BK_USR, 8'h00, 3'h0, 64'ha5c3, 1'b1, ERR_NONE, 16'h0000);
    cmd(OP_READ, BK_USR, 8'h00, 3'h0, 64'h0, 1'b1, ERR_NONE, 16'ha5c3);
    cmd(OP_BWRITE, BK_USR, 8'h04, 3'h4, 64'h4444_3333_2222_1111, 1'b1, ERR_NONE, 16'h0000);
    cmd(OP_BERASE, BK_USR, 8'h05, 3'h2, 64'h0, 1'b1, ERR_NONE, 16'h0000);
    for (int k = 0; k < 4; k++) begin
      e = (k == 1 || k == 2) ? ERASE_VAL : 16'h1111 * (k[15:0] + 16'h0001);
      cmd(OP_READ, BK_USR, 8'h04 + k[7:0], 3'h0, 64'h0, 1'b1, ERR_NONE, e);
    end
    $display("block test done");
  endtask : t_block
  task automatic t_refuse();
    tmb_op_t op [10] = '{OP_BWRITE, OP_BERASE, OP_BWRITE, OP_BWRITE, OP_BERASE,
      OP_BERASE, OP_PLOCK, OP_PLOCK, OP_WRITE, OP_BWRITE};
    tmb_bank_t bk [10] = '{BK_USR, BK_USR, BK_USR, BK_UII, BK_UII, BK_USR, BK_UII, BK_USR, BK_TID, BK_TID};
    logic [7:0] wp [10] = '{8'h02, 8'h04, 8'h08, 8'h00, 8'h02, 8'hd4, 8'h04, 8'h0d, 8'h00, 8'h00};
    logic [2:0] wc [10] = '{3'h3, 3'h0, 3'h5, 3'h1, 3'h2, 3'h1, 3'h0, 3'h0, 3'h0, 3'h1};
    logic [3:0] er [10] = '{ERR_OVERRUN, ERR_OVERRUN, ERR_OVERRUN, ERR_OTHER, ERR_OTHER,
      ERR_OVERRUN, ERR_OTHER, ERR_OTHER, ERR_LOCKED, ERR_LOCKED};
    for (int i = 0; i < 10; i++) begin
      cmd(op[i], bk[i], wp[i], wc[i], 64'h0, 1'b0, er[i], 16'h0000);
    end
    cmd(OP_READ, BK_USR, 8'h02, 3'h0, 64'h0, 1'b1, ERR_NONE, 16'h5a2e);
    cmd(OP_READ, BK_USR, 8'h08, 3'h0, 64'h0, 1'b1, ERR_NONE, 16'h5a34);
    $display("refusal test done");
  endtask : t_refuse
  task automatic t_plock();
    cmd(OP_PLOCK, BK_USR, 8'h0c, 3'h0, 64'h0, 1'b1, ERR_NONE, 16'h0000);
    cmd(OP_WRITE, BK_USR, 8'h0f, 3'h0, 64'h0, 1'b0, ERR_LOCKED, 16'h0000);
    cmd(OP_READ, BK_USR, 8'hcc, 3'h0, 64'h0, 1'b1, ERR_NONE, 16'h4000);
    cmd(OP_READ, BK_USR, 8'h0f, 3'h0, 64'h0, 1'b1, ERR_NONE, 16'h5a3b);
    $display("permalock test done");
  endtask : t_plock
  task automatic t_modes();
    logic seen;
    bsync_req = 1'b1;
    step();
    bsync_req = 1'b0;
    seen = bsync_ack;
    step();
    seen = seen | bsync_ack;
    cmp_bit("bsync_ack", 1'b1, seen);
    reader_first_over = 1'b1;
    step();
    reader_first_over = 1'b0;
    step();
    cmp_bit("listen_first_active", 1'b1, listen_first_active);
    cmp_bit("cmd_ready", 1'b0, cmd_ready);
    $display("mode test done");
  endtask : t_modes
  task automatic t_reboot();
    logic seen;
    int n;
    n = 0;
    srst = 1'b1;
    DUT.mem[ADR_TOTAL] = 16'h0000;
    DUT.mem[ADR_BATT] = 16'h0000;
    step();
    step();
    srst = 1'b0;
    while (boot_done !== 1'b1 && n < 20) begin
      step();
      n++;
    end
    cmp_bit("reader_first_protocol", 1'b1, reader_first_protocol);
    cmp_bit("listen_first_active", 1'b0, listen_first_active);
    cmp_bit("cmd_ready", 1'b1, cmd_ready);
    cmp_bit("bap_active", 1'b0, bap_active);
    bsync_req = 1'b1;
    step();
    bsync_req = 1'b0;
    seen = bsync_ack;
    step();
    seen = seen | bsync_ack;
    cmp_bit("bsync_ack", 1'b0, seen);
    reader_first_over = 1'b1;
    step();
    reader_first_over = 1'b0;
    cmp_bit("reader_first_protocol", 1'b1, reader_first_protocol);
    cmd(OP_READ, BK_USR, 8'h00, 3'h0, 64'h0, 1'b1, ERR_NONE, 16'ha5c3);
    cmd(OP_WRITE, BK_USR, 8'h0f, 3'h0, 64'h0, 1'b0, ERR_LOCKED, 16'h0000);
    $display("reboot test done");
  endtask : t_reboot
  task automatic give_verdict();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict
  initial begin
    srst = 1'b1;
    reader_first_seen = 1'b0;
    reader_first_over = 1'b0;
    bsync_req = 1'b0;
    for (int i = 0; i < NVM_WORDS; i++) begin
      DUT.mem[i] = {8'h5a, i[7:0]};
    end
    for (int i = 8'hf8; i <= 8'hfc; i++) begin
      DUT.mem[i] = 16'h0000;
    end
    DUT.mem[ADR_PCW] = PCW_VAL;
    DUT.mem[ADR_BATT] = 16'h0001;
    DUT.mem[ADR_TOTAL] = 16'h0001;
    repeat (16) @(posedge mclk);
    #1;
    srst = 1'b0;
    while (boot_done !== 1'b1 && cycles < 60) begin
      step();
    end
    t_boot();
    t_bounds();
    t_block();
    t_refuse();
    t_plock();
    t_modes();
    t_reboot();
    give_verdict();
  end
endmodule : tmb_bank_access_tb
